// *** rtl/rmcs_reg_bank.v ***
// What this block does
// R1 - fill window lasts (m+1) ms, m four bits, 1 to 16 ms
// R2 - leak window is (n+1) fill windows, n resets to 3
// R3 - bucket size zero switches the activity monitor off, no alarm
// R4 - nonzero bucket size below raise level is rejected; resets to 20
// R5 - raise level taken only above clear level and within bucket size; resets 15
// R6 - clear level taken only below raise level; resets 10
// R7 - bucket fills per idle fill window, drains per leak window, alarm hysteresis
// R8 - freerun trim is 11-bit two's complement over two bytes, resets zero
// R9 - disqualify span 10 bits, resets 110, also the pull-in range
// R10 - qualify span 10 bits unsigned, resets 100
// R11 - qualify delay six bits in seconds, resets 10
// R12 - readout index accepts 1 to 12 only, resets 1
// R13 - readout shows 12-bit offset, -2048 when out of range
// R14 - readout high nibble carries the detected frequency code
// R15 - activity flags per reference plus both cross-couple inputs, 1 means active
// R16 - qualified flags per reference, 1 means qualified
// R17 - mode bits: align 0, holdover source 2, revertive 3, auto 4, pull-in policy 5
// R18 - phase align bit picks arbitrary phase or aligned phase
// R19 - holdover source bit picks device history or user history
// R20 - manual mode out of pull-in: policy 0 keeps tracking, 1 stops
// R21 - bandwidth code 0 to 10 valid, reset 6
// R22 - lsb read latches upper bytes into a holding register
// R23 - multibyte writes held, committed on the most significant byte
`timescale 1ns/100ps
`include "rmcs_defines.vh"

module rmcs_reg_bank #(
  parameter MS_CYCLES = `RMCS_MS_CYCLES,
  parameter NUM_REFS  = 12
) (
  input  wire                   clk,
  input  wire                   reset,
  input  wire                   spi_cs_n,
  input  wire                   spi_sclk,
  input  wire                   spi_sdi,
  output reg                    spi_sdo,
  output wire                   spi_sdo_oe,
  input  wire [NUM_REFS-1:0]    ref_edge,
  input  wire                   primary_crosscouple_sync_input,
  input  wire                   secondary_crosscouple_sync_input,
  input  wire [12*NUM_REFS-1:0] ref_offset,
  input  wire [NUM_REFS-1:0]    ref_out_of_range,
  input  wire [4*NUM_REFS-1:0]  ref_freq_code,
  input  wire [NUM_REFS-1:0]    ref_qualified,
  input  wire                   selected_ref_outside_pullin,
  output reg  [10:0]            freerun_trim,
  output reg  [9:0]             disqualify_span,
  output reg  [9:0]             qualify_span,
  output reg  [5:0]             qualify_delay_seconds,
  output reg  [4:0]             primary_loop_bandwidth,
  output reg                    phase_align,
  output reg                    holdover_source_select,
  output reg                    revertive,
  output reg                    auto_select,
  output reg                    out_of_pullin_policy,
  output reg                    primary_track_enable,
  output reg  [NUM_REFS+1:0]    activity_alarm
);

  localparam NMON = NUM_REFS + 2;

  // spi slave, pins sampled on clk so sclk must be well below clk/4
  reg        sclk_q;
  reg [4:0]  bit_cnt;
  reg [7:0]  rx_shift;
  reg [7:0]  cmd;
  reg [7:0]  tx_shift;
  wire       sclk_rise = spi_sclk & ~sclk_q;
  wire       sclk_fall = ~spi_sclk & sclk_q;
  wire       cmd_done  = sclk_rise & ~spi_cs_n & (bit_cnt == 5'd7);
  wire       data_done = sclk_rise & ~spi_cs_n & (bit_cnt == 5'd15);
  wire [7:0] rx_byte   = {rx_shift[6:0], spi_sdi};
  wire       wr_strobe = data_done & ~cmd[7];
  wire [6:0] wr_addr   = cmd[6:0];
  wire       rd_strobe = cmd_done & rx_byte[7];
  wire [6:0] rd_addr   = rx_byte[6:0];

  assign spi_sdo_oe = ~spi_cs_n;

  // register storage
  reg [3:0]  fill_window;
  reg [3:0]  leak_window_multiple;
  reg [5:0]  bucket_capacity;
  reg [5:0]  alarm_raise_level;
  reg [5:0]  alarm_clear_level;
  reg [3:0]  readout_reference_index;
  reg [7:0]  primary_generator_mode;
  reg [7:0]  wr_hold;
  reg [15:0] rd_hold;

  function lsb_of_pair;
    input [6:0] a;
    begin
      lsb_of_pair = (a == `RMCS_ADDR_TRIM_LO) | (a == `RMCS_ADDR_DISQ_LO) |
                    (a == `RMCS_ADDR_QUAL_LO) | (a == `RMCS_ADDR_OFFSET_LO) |
                    (a == `RMCS_ADDR_ACT_LO) | (a == `RMCS_ADDR_QFLAG_LO);
    end
  endfunction

  // readout of the indexed reference
  reg [3:0]  sel_idx;
  reg [11:0] sel_offset;
  reg [3:0]  sel_freq;
  reg        sel_oor;
  integer    k;
  always @* begin
    sel_idx    = readout_reference_index - 4'h1;
    sel_offset = 12'h000;
    sel_freq   = 4'h0;
    sel_oor    = 1'b0;
    for (k = 0; k < NUM_REFS; k = k + 1) begin
      if (sel_idx == k[3:0]) begin
        sel_offset = ref_offset[12*k +: 12];
        sel_freq   = ref_freq_code[4*k +: 4];
        sel_oor    = ref_out_of_range[k];
      end
    end
  end

  wire [11:0] shown_offset = sel_oor ? `RMCS_OFFSET_OOR : sel_offset; // R13
  wire [15:0] offset_word  = {sel_freq, shown_offset}; // R14
  wire [15:0] act_word     = {2'b00, ~activity_alarm[NMON-1:0]}; // R15
  wire [15:0] qual_word    = {{(16-NUM_REFS){1'b0}}, ref_qualified}; // R16

  // word view of multibyte registers, addressed by their lsb byte
  reg [15:0] word_val;
  reg [7:0]  byte_val;
  always @* begin
    case (rd_addr)
      `RMCS_ADDR_TRIM_LO:   word_val = {5'h00, freerun_trim};
      `RMCS_ADDR_DISQ_LO:   word_val = {6'h00, disqualify_span};
      `RMCS_ADDR_QUAL_LO:   word_val = {6'h00, qualify_span};
      `RMCS_ADDR_OFFSET_LO: word_val = offset_word;
      `RMCS_ADDR_ACT_LO:    word_val = act_word;
      `RMCS_ADDR_QFLAG_LO:  word_val = qual_word;
      default:              word_val = 16'h0000;
    endcase
    case (rd_addr)
      `RMCS_ADDR_FILL_WIN:   byte_val = {4'h0, fill_window};
      `RMCS_ADDR_LEAK_WIN:   byte_val = {4'h0, leak_window_multiple};
      `RMCS_ADDR_BUCKET:     byte_val = {2'b00, bucket_capacity};
      `RMCS_ADDR_RAISE:      byte_val = {2'b00, alarm_raise_level};
      `RMCS_ADDR_CLEAR:      byte_val = {2'b00, alarm_clear_level};
      `RMCS_ADDR_QUAL_DELAY: byte_val = {2'b00, qualify_delay_seconds};
      `RMCS_ADDR_REF_INDEX:  byte_val = {4'h0, readout_reference_index};
      `RMCS_ADDR_MODE:       byte_val = primary_generator_mode;
      `RMCS_ADDR_BANDWIDTH:  byte_val = {3'b000, primary_loop_bandwidth};
      `RMCS_ADDR_TRIM_HI,
      `RMCS_ADDR_DISQ_HI,
      `RMCS_ADDR_QUAL_HI,
      `RMCS_ADDR_OFFSET_HI,
      `RMCS_ADDR_ACT_HI,
      `RMCS_ADDR_QFLAG_HI:   byte_val = rd_hold[15:8]; // R22
      default:               byte_val = lsb_of_pair(rd_addr) ? word_val[7:0] : 8'h00;
    endcase
  end

  // serial shifting
  always @(posedge clk) begin
    if (reset) begin
      sclk_q   <= 1'b0;
      bit_cnt  <= 5'd0;
      rx_shift <= 8'h00;
      cmd      <= 8'h00;
      tx_shift <= 8'h00;
      spi_sdo  <= 1'b0;
      rd_hold  <= 16'h0000;
    end else begin
      sclk_q <= spi_sclk;
      if (spi_cs_n) begin
        bit_cnt <= 5'd0;
      end else if (sclk_rise) begin
        rx_shift <= rx_byte;
        if (bit_cnt != 5'd16)
          bit_cnt <= bit_cnt + 5'd1;
        if (cmd_done)
          cmd <= rx_byte;
      end
      if (rd_strobe) begin
        tx_shift <= {byte_val[6:0], 1'b0};
        spi_sdo  <= byte_val[7];
        if (lsb_of_pair(rd_addr))
          rd_hold <= word_val; // R22
      end else if (sclk_fall & ~spi_cs_n & (bit_cnt > 5'd8)) begin
        spi_sdo  <= tx_shift[7];
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  // register writes with validity checks
  wire [5:0] wd6 = rx_byte[5:0];
  always @(posedge clk) begin
    if (reset) begin
      fill_window             <= `RMCS_RST_FILL_WIN;
      leak_window_multiple    <= `RMCS_RST_LEAK_WIN; // R2
      bucket_capacity         <= `RMCS_RST_BUCKET; // R4
      alarm_raise_level       <= `RMCS_RST_RAISE; // R5
      alarm_clear_level       <= `RMCS_RST_CLEAR; // R6
      freerun_trim            <= `RMCS_RST_TRIM; // R8
      disqualify_span         <= `RMCS_RST_DISQ; // R9
      qualify_span            <= `RMCS_RST_QUAL; // R10
      qualify_delay_seconds   <= `RMCS_RST_QUAL_DELAY; // R11
      readout_reference_index <= `RMCS_RST_REF_INDEX; // R12
      primary_generator_mode  <= `RMCS_RST_MODE; // R17
      primary_loop_bandwidth  <= `RMCS_RST_BANDWIDTH; // R21
      wr_hold                 <= 8'h00;
    end else if (wr_strobe) begin
      case (wr_addr)
        `RMCS_ADDR_FILL_WIN: fill_window <= rx_byte[3:0]; // R1
        `RMCS_ADDR_LEAK_WIN: leak_window_multiple <= rx_byte[3:0]; // R2
        `RMCS_ADDR_BUCKET:
          if (rx_byte[7:6] == 2'b00 && (wd6 == 6'h00 || wd6 >= alarm_raise_level))
            bucket_capacity <= wd6; // R4
        `RMCS_ADDR_RAISE:
          if (rx_byte[7:6] == 2'b00 && wd6 != 6'h00 && wd6 <= `RMCS_RAISE_MAX &&
              wd6 > alarm_clear_level && wd6 <= bucket_capacity)
            alarm_raise_level <= wd6; // R5
        `RMCS_ADDR_CLEAR:
          if (rx_byte[7:6] == 2'b00 && wd6 <= `RMCS_CLEAR_MAX && wd6 < alarm_raise_level)
            alarm_clear_level <= wd6; // R6
        `RMCS_ADDR_TRIM_LO,
        `RMCS_ADDR_DISQ_LO,
        `RMCS_ADDR_QUAL_LO:  wr_hold <= rx_byte; // R23
        `RMCS_ADDR_TRIM_HI:  freerun_trim <= {rx_byte[2:0], wr_hold}; // R8 R23
        `RMCS_ADDR_DISQ_HI:  disqualify_span <= {rx_byte[1:0], wr_hold}; // R9 R23
        `RMCS_ADDR_QUAL_HI:  qualify_span <= {rx_byte[1:0], wr_hold}; // R10 R23
        `RMCS_ADDR_QUAL_DELAY: qualify_delay_seconds <= wd6; // R11
        `RMCS_ADDR_REF_INDEX:
          if (rx_byte != 8'h00 && rx_byte <= {4'h0, `RMCS_REF_MAX})
            readout_reference_index <= rx_byte[3:0]; // R12
        `RMCS_ADDR_MODE: primary_generator_mode <= rx_byte & `RMCS_MODE_MASK; // R17
        `RMCS_ADDR_BANDWIDTH:
          if (rx_byte <= {3'b000, `RMCS_BW_MAX})
            primary_loop_bandwidth <= rx_byte[4:0]; // R21
        default: wr_hold <= wr_hold;
      endcase
    end
  end

  // mode decode toward the timing generator
  always @(posedge clk) begin
    if (reset) begin
      phase_align            <= 1'b0;
      holdover_source_select <= 1'b0;
      revertive              <= 1'b0;
      auto_select            <= 1'b0;
      out_of_pullin_policy   <= 1'b0;
      primary_track_enable   <= 1'b1;
    end else begin
      phase_align            <= primary_generator_mode[`RMCS_MODE_PHASE_ALIGN]; // R18
      holdover_source_select <= primary_generator_mode[`RMCS_MODE_HO_SOURCE]; // R19
      revertive              <= primary_generator_mode[`RMCS_MODE_REVERTIVE];
      auto_select            <= primary_generator_mode[`RMCS_MODE_AUTO];
      out_of_pullin_policy   <= primary_generator_mode[`RMCS_MODE_PULLIN_POL];
      // tracking stops only in manual mode with policy 1 while the selected reference is outside pull-in
      primary_track_enable   <= ~(~primary_generator_mode[`RMCS_MODE_AUTO] &
                                  selected_ref_outside_pullin &
                                  primary_generator_mode[`RMCS_MODE_PULLIN_POL]); // R20
    end
  end

  // leaky bucket activity monitor
  reg [16:0] ms_cnt;
  reg [3:0]  win_ms;
  reg [3:0]  leak_cnt;
  reg [NMON-1:0] seen;
  reg [5:0]  bucket [0:NMON-1];
  wire       ms_tick  = (ms_cnt == MS_CYCLES - 1);
  wire       fill_end = ms_tick & (win_ms == fill_window); // R1
  wire       leak_end = fill_end & (leak_cnt == leak_window_multiple); // R2
  wire [NMON-1:0] act_in = {secondary_crosscouple_sync_input,
                            primary_crosscouple_sync_input, ref_edge};

  function [5:0] next_level;
    input [5:0] lvl;
    input       idle;
    input       drain;
    input [5:0] cap;
    reg   [5:0] t;
    begin
      t = (idle && lvl < cap) ? lvl + 6'd1 : lvl;
      next_level = (drain && t != 6'd0) ? t - 6'd1 : t;
    end
  endfunction

  integer   i;
  always @(posedge clk) begin
    if (reset) begin
      ms_cnt         <= 17'd0;
      win_ms         <= 4'h0;
      leak_cnt       <= 4'h0;
      seen           <= {NMON{1'b0}};
      activity_alarm <= {NMON{1'b0}};
      for (i = 0; i < NMON; i = i + 1)
        bucket[i] <= 6'd0;
    end else begin
      ms_cnt <= ms_tick ? 17'd0 : ms_cnt + 17'd1;
      if (fill_end) begin
        win_ms   <= 4'h0;
        leak_cnt <= leak_end ? 4'h0 : leak_cnt + 4'h1;
      end else if (ms_tick) begin
        win_ms <= win_ms + 4'h1;
      end
      // activity in the closing cycle counts for the next window, not lost
      seen <= fill_end ? act_in : (seen | act_in);
      for (i = 0; i < NMON; i = i + 1) begin
        if (bucket_capacity == 6'd0) begin
          bucket[i]         <= 6'd0;
          activity_alarm[i] <= 1'b0; // R3
        end else if (fill_end) begin
          bucket[i] <= next_level(bucket[i], ~seen[i], leak_end, bucket_capacity); // R7
          if (next_level(bucket[i], ~seen[i], leak_end, bucket_capacity)
              >= alarm_raise_level)
            activity_alarm[i] <= 1'b1; // R7
          else if (next_level(bucket[i], ~seen[i], leak_end, bucket_capacity)
                   <= alarm_clear_level)
            activity_alarm[i] <= 1'b0; // R7
        end
      end
    end
  end

endmodule // rmcs_reg_bank

// *** rtl/rmcs_defines.vh ***
`ifndef RMCS_DEFINES_VH
`define RMCS_DEFINES_VH

// register byte addresses
`define RMCS_ADDR_FILL_WIN      7'h09
`define RMCS_ADDR_LEAK_WIN      7'h0A
`define RMCS_ADDR_BUCKET        7'h0B
`define RMCS_ADDR_RAISE         7'h0C
`define RMCS_ADDR_CLEAR         7'h0D
`define RMCS_ADDR_TRIM_LO       7'h0E
`define RMCS_ADDR_TRIM_HI       7'h0F
`define RMCS_ADDR_DISQ_LO       7'h10
`define RMCS_ADDR_DISQ_HI       7'h11
`define RMCS_ADDR_QUAL_LO       7'h12
`define RMCS_ADDR_QUAL_HI       7'h13
`define RMCS_ADDR_QUAL_DELAY    7'h14
`define RMCS_ADDR_REF_INDEX     7'h15
`define RMCS_ADDR_OFFSET_LO     7'h16
`define RMCS_ADDR_OFFSET_HI     7'h17
`define RMCS_ADDR_ACT_LO        7'h18
`define RMCS_ADDR_ACT_HI        7'h19
`define RMCS_ADDR_QFLAG_LO      7'h1A
`define RMCS_ADDR_QFLAG_HI      7'h1B
`define RMCS_ADDR_MODE          7'h1C
`define RMCS_ADDR_BANDWIDTH     7'h1D

// reset values
`define RMCS_RST_FILL_WIN       4'h0
`define RMCS_RST_LEAK_WIN       4'h3
`define RMCS_RST_BUCKET         6'h14
`define RMCS_RST_RAISE          6'h0F
`define RMCS_RST_CLEAR          6'h0A
`define RMCS_RST_TRIM           11'h000
`define RMCS_RST_DISQ           10'h06E
`define RMCS_RST_QUAL           10'h064
`define RMCS_RST_QUAL_DELAY     6'h0A
`define RMCS_RST_REF_INDEX      4'h1
`define RMCS_RST_MODE           8'h00
`define RMCS_RST_BANDWIDTH      5'h06

// field limits and positions
`define RMCS_REF_MAX            4'hC
`define RMCS_RAISE_MAX          6'h3F
`define RMCS_CLEAR_MAX          6'h3E
`define RMCS_BW_MAX             5'h0A
`define RMCS_MODE_MASK          8'h3D
`define RMCS_MODE_PHASE_ALIGN   0
`define RMCS_MODE_HO_SOURCE     2
`define RMCS_MODE_REVERTIVE     3
`define RMCS_MODE_AUTO          4
`define RMCS_MODE_PULLIN_POL    5
`define RMCS_OFFSET_OOR         12'h800

// timing
`define RMCS_CLK_PERIOD_NS      20
`define RMCS_MS_NS              1000000
`define RMCS_MS_CYCLES          (`RMCS_MS_NS / `RMCS_CLK_PERIOD_NS)

`endif

// *** dv/rmcs_checker.sv ***
`timescale 1ns/100ps
module rmcs_checker #(
  parameter MS_CYCLES = 10,
  parameter NUM_REFS  = 12
) (
  input wire logic                clk,
  input wire logic                reset,
  input wire logic                spi_cs_n,
  input wire logic                spi_sdo_oe,
  input wire logic [NUM_REFS-1:0] ref_edge,
  input wire logic                selected_ref_outside_pullin,
  input wire logic [10:0]         freerun_trim,
  input wire logic [9:0]          disqualify_span,
  input wire logic [9:0]          qualify_span,
  input wire logic [4:0]          primary_loop_bandwidth,
  input wire logic                phase_align,
  input wire logic                auto_select,
  input wire logic                out_of_pullin_policy,
  input wire logic                primary_track_enable,
  input wire logic [NUM_REFS+1:0] activity_alarm
);
  integer idle_run;
  logic   idle_seen;
  // lenient by two cycles: window phase against our count is unknown
  always_ff @(posedge clk) begin
    if (reset) begin
      idle_run  <= 0;
      idle_seen <= 1'b0;
    end else begin
      idle_run <= ref_edge[0] ? 0 : idle_run + 1;
      if (idle_run >= MS_CYCLES - 2) idle_seen <= 1'b1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence manual_pullin_out;
    (!auto_select && out_of_pullin_policy && selected_ref_outside_pullin)[*3];
  endsequence
  sequence pullin_follow;
    (!out_of_pullin_policy)[*2];
  endsequence
  chk_reset_defaults: assert property ($fell(reset) |-> freerun_trim == 11'h000 &&
    disqualify_span == 10'h06E && qualify_span == 10'h064 && !phase_align &&
    primary_loop_bandwidth == 5'h06 && activity_alarm == '0 && primary_track_enable)
    else $error("register defaults wrong after reset");
  chk_bw_legal: assert property (primary_loop_bandwidth <= 5'h0A)
    else $error("reserved bandwidth code taken");
  chk_quiet_idle_bus: assert property (spi_cs_n [*8] |-> $stable(freerun_trim) &&
    $stable(disqualify_span) && $stable(qualify_span))
    else $error("register changed with bus idle");
  chk_oe_follows_cs: assert property (spi_sdo_oe == !spi_cs_n)
    else $error("output enable does not follow select");
  chk_track_stop: assert property (manual_pullin_out |-> !primary_track_enable)
    else $error("tracking kept outside pull-in");
  chk_track_follow: assert property (pullin_follow |-> primary_track_enable)
    else $error("tracking dropped with follow policy");
  chk_track_auto: assert property (auto_select [*2] |-> primary_track_enable)
    else $error("tracking dropped in auto mode");
  chk_alarm_needs_idle: assert property (activity_alarm[0] |-> idle_seen)
    else $error("alarm without an idle fill window");
endmodule // rmcs_checker

bind rmcs_reg_bank rmcs_checker #(.MS_CYCLES(MS_CYCLES), .NUM_REFS(NUM_REFS)) chk_u (
  .clk(clk), .reset(reset), .spi_cs_n(spi_cs_n), .spi_sdo_oe(spi_sdo_oe),
  .ref_edge(ref_edge), .selected_ref_outside_pullin(selected_ref_outside_pullin),
  .freerun_trim(freerun_trim), .disqualify_span(disqualify_span),
  .qualify_span(qualify_span), .primary_loop_bandwidth(primary_loop_bandwidth),
  .phase_align(phase_align), .auto_select(auto_select),
  .out_of_pullin_policy(out_of_pullin_policy),
  .primary_track_enable(primary_track_enable), .activity_alarm(activity_alarm));

// *** dv/rmcs_spi_host.sv ***
`timescale 1ns/100ps
module rmcs_spi_host (
  input  wire logic clk,
  input  wire logic sdo,
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end
  // three clk per sclk phase, margin over the two-cycle minimum
  task automatic xfer(input logic [7:0] b0, input logic [7:0] b1, output logic [7:0] rd);
    logic [15:0] w;
    integer      i;
    w  = {b0, b1};
    rd = 8'h00;
    @(negedge clk) cs_n = 1'b0;
    for (i = 15; i >= 0; i--) begin
      sdi = w[i];
      repeat (3) @(negedge clk);
      sclk = 1'b1;
      if (i < 8) rd = {rd[6:0], sdo};
      repeat (3) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (3) @(negedge clk);
    cs_n = 1'b1;
    sdi  = ~sdi;
    repeat (3) @(negedge clk);
  endtask
endmodule // rmcs_spi_host

// *** dv/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  logic         clk = 1'b0;
  logic         reset;
  logic [11:0]  ref_edge, oor, qual;
  logic [143:0] ref_offset;
  logic [47:0]  fcode;
  logic         xs0, xs1, outside;
  wire          cs_n, sclk, sdi, sdo, sdo_oe, align, ho_src, revert, auto_sel, pol, track;
  wire  [10:0]  trim;
  wire  [9:0]   disq, qspan;
  wire  [5:0]   qdelay;
  wire  [4:0]   bw;
  wire  [13:0]  alarm;
  int           err_total, checked, i;
  logic [15:0]  dflt [0:14] = '{16'h0900, 16'h0A03, 16'h0B14, 16'h0C0F, 16'h0D0A, 16'h0E00,
    16'h0F00, 16'h106E, 16'h1100, 16'h1264, 16'h1300, 16'h140A, 16'h1501, 16'h1C00, 16'h1D06};
  logic [23:0]  acc [0:17] = '{24'h0C160F, 24'h0C0A0F, 24'h0C000F, 24'h0D0F0A, 24'h0D0E0E,
    24'h0D0A0A, 24'h0B0E14, 24'h0B0F0F, 24'h0B0000, 24'h0B1414, 24'h150001, 24'h150D01,
    24'h150C0C, 24'h1D0B06, 24'h1D0A0A, 24'h1CFF3D, 24'h143F3F, 24'h1800FF};

  always #10 clk = ~clk;

  rmcs_spi_host host_u (.clk(clk), .sdo(sdo), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));

  rmcs_reg_bank #(.MS_CYCLES(10), .NUM_REFS(12)) dut_u (
    .clk(clk), .reset(reset), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdi(sdi),
    .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .ref_edge(ref_edge),
    .primary_crosscouple_sync_input(xs0), .secondary_crosscouple_sync_input(xs1),
    .ref_offset(ref_offset), .ref_out_of_range(oor), .ref_freq_code(fcode),
    .ref_qualified(qual), .selected_ref_outside_pullin(outside), .freerun_trim(trim),
    .disqualify_span(disq), .qualify_span(qspan), .qualify_delay_seconds(qdelay),
    .primary_loop_bandwidth(bw), .phase_align(align), .holdover_source_select(ho_src),
    .revertive(revert), .auto_select(auto_sel), .out_of_pullin_policy(pol),
    .primary_track_enable(track), .activity_alarm(alarm));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    host_u.xfer({1'b0, a[6:0]}, d, x);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] x;
    host_u.xfer({1'b1, a[6:0]}, 8'h00, x);
    chk("read byte", {a, exp}, {a, x});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    err_total++;
    test_done;
  end

  initial begin
    reset = 1'b1;
    ref_edge = '1;
    oor = '0;
    qual = '0;
    ref_offset = '0;
    fcode = '0;
    xs0 = 1'b1;
    xs1 = 1'b1;
    outside = 1'b0;
    repeat (16) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    for (i = 0; i < 15; i++) rd(dflt[i][15:8], dflt[i][7:0]);
    rd(8'h7F, 8'h00);
    for (i = 0; i < 18; i++) begin
      wr(acc[i][23:16], acc[i][15:8]);
      rd(acc[i][23:16], acc[i][7:0]);
    end
    chk("mode bits", 16'h3F1F, {2'b0, qdelay, 3'b0, pol, auto_sel, revert, ho_src, align});
    wr(8'h1C, 8'h00);
    wr(8'h0E, 8'hFF);
    chk("trim before msb", 16'h0000, {5'h0, trim});
    wr(8'h0F, 8'h04);
    chk("trim committed", 16'h04FF, {5'h0, trim});
    wr(8'h12, 8'h34);
    wr(8'h13, 8'h03);
    chk("qualify span", 16'h0334, {6'h0, qspan});
    wr(8'h10, 8'hFF);
    wr(8'h11, 8'h03);
    chk("disqualify span", 16'h03FF, {6'h0, disq});
    ref_offset[143:132] = 12'h123;
    fcode[47:44] = 4'hD;
    rd(8'h16, 8'h23);
    ref_offset[143:132] = 12'hABC;
    rd(8'h17, 8'hD1);
    oor[11] = 1'b1;
    rd(8'h16, 8'h00);
    rd(8'h17, 8'hD8);
    qual = 12'hA5C;
    rd(8'h1A, 8'h5C);
    rd(8'h1B, 8'h0A);
    rd(8'h18, 8'hFF);
    rd(8'h19, 8'h3F);
    ref_edge[0] = 1'b0;
    xs1 = 1'b0;
    idle(400);
    chk("alarms idle", 16'h2001, {2'b0, alarm});
    rd(8'h18, 8'hFE);
    rd(8'h19, 8'h1F);
    ref_edge[0] = 1'b1;
    xs1 = 1'b1;
    idle(900);
    chk("alarms cleared", 16'h0000, {2'b0, alarm});
    wr(8'h0B, 8'h00);
    ref_edge[0] = 1'b0;
    idle(400);
    chk("monitor off", 16'h0000, {2'b0, alarm});
    ref_edge[0] = 1'b1;
    wr(8'h1C, 8'h20);
    outside = 1'b1;
    idle(4);
    chk("track stopped", 16'h0000, {15'h0, track});
    outside = 1'b0;
    idle(4);
    chk("track follows", 16'h0001, {15'h0, track});
    outside = 1'b1;
    wr(8'h1C, 8'h30);
    chk("track in auto", 16'h0001, {15'h0, track});
    test_done;
  end
endmodule // tb_top
